// File: clk_synth_map.svh
// Register offsets, field positions, reset values and timing counts of the clock control block
// *****************************************************************************
// How it works
// - Lock flag in the control register shows whether the synthesizer is locked.
// - With the mode strap high, system reset stays asserted at power-up until the synthesizer reports lock.
// - Prescale and modulus sit in the feedback path; changing them forces a relock.
// - Divide select zero divides the VCO by four, one divides it by two.
// - Changing divide select alters system clock at once without any relock.
// - A rising edge at the comparator input forces relock; the lock flag follows.
// - Slow reference: sys = 4*ref*(modulus+1)*2^(2*prescale+divide select).
// - Fast reference: sys = ref/128 * 4*(modulus+1)*2^(2*prescale+divide select).
// - Control register resets to 3F00 hex.
// - Mode strap low at reset disables the PLL; external clock used directly.
// - A multiplier is produced for every modulus and prescale/divide setting.
// *****************************************************************************
`ifndef CLK_SYNTH_MAP_SVH
`define CLK_SYNTH_MAP_SVH

// *****************************************************************************
// Register offsets (byte addresses)
// *****************************************************************************
`define SYNTH_CTRL_OFS    12'h000
`define IRQ_STATUS_OFS    12'h004
`define IRQ_MASK_OFS      12'h008
`define FREQ_MULT_OFS     12'h00C
`define MODE_STAT_OFS     12'h010

// *****************************************************************************
// Control register fields
// *****************************************************************************
`define CTRL_PRESCALE_POS 15
`define CTRL_DIVSEL_POS   14
`define CTRL_MOD_MSB      13
`define CTRL_MOD_LSB      8
`define CTRL_LOCK_POS     3
`define CTRL_RESET        16'h3F00

// Interrupt status bits
`define IRQ_LOCK_GAIN_POS 0
`define IRQ_LOCK_LOSS_POS 1

// *****************************************************************************
// Timing
// *****************************************************************************
`define CLOCK_PERIOD_NS   50
`define RELOCK_TIME_NS    100000
`define RELOCK_CYCLES     ((`RELOCK_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

// File: clk_synth_pkg.sv
// Types shared by the clock control block
package clk_synth_pkg;
  typedef enum logic [1:0] {
    LOCK_STRAP    = 2'b00,
    LOCK_ACQUIRE  = 2'b01,
    LOCK_LOCKED   = 2'b10,
    LOCK_BYPASS   = 2'b11
  } lock_state_e;

  typedef struct packed {
    logic       prescale;
    logic       div_sel;
    logic [5:0] modulus;
  } synth_cfg_s;
endpackage

// File: synth_cfg_if.sv
// Interface carrying the synthesizer settings and multiplier between modules
interface synth_cfg_if;
  import clk_synth_pkg::*;
  synth_cfg_s  cfg;
  logic [11:0] mult_slow;
  logic [10:0] mult_fast_x32;

  modport ctrl (output cfg, input mult_slow, input mult_fast_x32);
  modport calc (input cfg, output mult_slow, output mult_fast_x32);
endinterface

// File: synth_mult_calc.sv
// Clock multiplier calculation from the synthesizer settings
module synth_mult_calc
  import clk_synth_pkg::*;
(
  synth_cfg_if.calc cfg_if
);
  logic [10:0] base;
  logic [1:0]  shift;

  // Slow multiplier is 4*(Y+1) shifted by 2W+X; fast is the same over 128, held times 32
  always_comb begin
    base  = {3'h0, {2'h0, cfg_if.cfg.modulus} + 8'h01} << 2;
    shift = {cfg_if.cfg.prescale, 1'b0} + {1'b0, cfg_if.cfg.div_sel};
    cfg_if.mult_slow     = 12'(base) << shift;
    cfg_if.mult_fast_x32 = 11'((12'(base) << shift) >> 2);
  end
endmodule // synth_mult_calc

// File: clk_synth_ctrl.sv
// Clock synthesizer control: APB registers, lock tracking, reset hold, bypass
`include "clk_synth_map.svh"

module clk_synth_ctrl
  import clk_synth_pkg::*;
#(
  parameter int RELOCK_CYCLES = `RELOCK_CYCLES
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        clock_mode_strap_i,
  input  wire logic        ref_clk_change_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             synth_lock_flag_o,
  output logic             sys_rst_n_o,
  output logic             pll_enable_o,
  output logic             vco_div2_o,
  output logic             relock_o,
  output logic      [7:0]  feedback_cfg_o,
  output logic             irq_o
);

  // *****************************************************************************
  // Strap and comparator input synchronisers
  // *****************************************************************************
  logic [2:0] strap_sync_reg;
  logic [2:0] ref_sync_reg;
  logic       strap_stable;
  logic       ref_change_evt;

  // Three flops each; only stages two and three are compared
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_sync_reg <= 3'h7;
      ref_sync_reg   <= 3'h0;
    end else begin
      strap_sync_reg <= {strap_sync_reg[1:0], clock_mode_strap_i};
      ref_sync_reg   <= {ref_sync_reg[1:0], ref_clk_change_i};
    end
  end
  assign strap_stable   = (strap_sync_reg[1] == strap_sync_reg[2]);
  assign ref_change_evt = ref_sync_reg[1] & ~ref_sync_reg[2];  // Rising edge on reference change

  // *****************************************************************************
  // Control register and APB
  // *****************************************************************************
  synth_cfg_if cfg_bus ();
  synth_mult_calc u_mult (.cfg_if(cfg_bus));

  synth_cfg_s  cfg_reg, cfg_next;
  logic [1:0]  irq_stat_reg, irq_stat_next;
  logic [1:0]  irq_mask_reg, irq_mask_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic        fb_change;
  logic [1:0]  irq_set;

  assign pready_o  = 1'b1;                              // Zero wait states
  assign wr_en     = psel_i & penable_i & pwrite_i;
  // Read data is loaded in the setup cycle so it stands through the access edge
  assign rd_en     = psel_i & ~penable_i & ~pwrite_i;
  assign pslverr_o = psel_i & penable_i & ~addr_ok;
  assign cfg_bus.cfg = cfg_reg;

  // Address decode
  always_comb begin
    unique case (paddr_i)
      `SYNTH_CTRL_OFS, `IRQ_STATUS_OFS, `IRQ_MASK_OFS,
      `FREQ_MULT_OFS, `MODE_STAT_OFS: addr_ok = 1'b1;
      default:                        addr_ok = 1'b0;
    endcase
  end

  // Next register values and read mux
  always_comb begin
    cfg_next      = cfg_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    prdata_next   = prdata_reg;
    fb_change     = 1'b0;
    if (wr_en && paddr_i == `SYNTH_CTRL_OFS) begin
      // Lock flag bit is not writable
      cfg_next.prescale = pwdata_i[`CTRL_PRESCALE_POS];
      cfg_next.div_sel  = pwdata_i[`CTRL_DIVSEL_POS];
      cfg_next.modulus  = pwdata_i[`CTRL_MOD_MSB:`CTRL_MOD_LSB];
      fb_change = (pwdata_i[`CTRL_PRESCALE_POS] != cfg_reg.prescale) ||
                  (pwdata_i[`CTRL_MOD_MSB:`CTRL_MOD_LSB] != cfg_reg.modulus);
    end
    if (wr_en && paddr_i == `IRQ_MASK_OFS) begin
      irq_mask_next = pwdata_i[1:0];
    end
    if (wr_en && paddr_i == `IRQ_STATUS_OFS) begin
      irq_stat_next = irq_stat_next & ~pwdata_i[1:0];
    end
    irq_stat_next = irq_stat_next | irq_set;            // Set wins over clear
    if (rd_en) begin
      unique case (paddr_i)
        `SYNTH_CTRL_OFS: prdata_next = {16'h0000, cfg_reg.prescale, cfg_reg.div_sel,
                                        cfg_reg.modulus, 4'h0, synth_lock_flag_o, 3'h0};
        `IRQ_STATUS_OFS: prdata_next = {30'h0, irq_stat_reg};
        `IRQ_MASK_OFS:   prdata_next = {30'h0, irq_mask_reg};
        `FREQ_MULT_OFS:  prdata_next = {5'h0, cfg_bus.mult_fast_x32, 4'h0,
                                        cfg_bus.mult_slow};
        `MODE_STAT_OFS:  prdata_next = {30'h0, sys_rst_n_o, pll_enable_o};
        default:         prdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Register stage
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_reg      <= synth_cfg_s'(8'(`CTRL_RESET >> `CTRL_MOD_LSB));
      irq_stat_reg <= 2'h0;
      irq_mask_reg <= 2'h0;
      prdata_reg   <= 32'h0000_0000;
    end else begin
      cfg_reg      <= cfg_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      prdata_reg   <= prdata_next;
    end
  end
  assign prdata_o = prdata_reg;
  assign irq_o    = |(irq_stat_reg & irq_mask_reg);

  // *****************************************************************************
  // Lock tracking, reset hold and bypass
  // *****************************************************************************
  lock_state_e lock_state_reg, lock_state_next;
  logic [31:0] relock_cnt_reg, relock_cnt_next;
  logic        lock_reg, lock_next;
  logic        rst_hold_reg, rst_hold_next;
  logic [1:0]  strap_cnt_reg, strap_cnt_next;

  // Strap decision waits until the pin level has filled all three sync stages
  always_comb begin
    strap_cnt_next = strap_cnt_reg;
    if (lock_state_reg == LOCK_STRAP && strap_cnt_reg != 2'h3) begin
      strap_cnt_next = strap_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_cnt_reg <= 2'h0;
    end else begin
      strap_cnt_reg <= strap_cnt_next;
    end
  end

  // Strap is sampled once stable after reset; then lock follows relock delay
  always_comb begin
    lock_state_next = lock_state_reg;
    relock_cnt_next = relock_cnt_reg;
    lock_next       = lock_reg;
    rst_hold_next   = rst_hold_reg;
    irq_set         = 2'h0;
    unique case (lock_state_reg)
      LOCK_STRAP: begin
        if (strap_stable && strap_cnt_reg == 2'h3) begin
          if (strap_sync_reg[2]) begin
            lock_state_next = LOCK_ACQUIRE;
            relock_cnt_next = 32'(RELOCK_CYCLES);
          end else begin
            lock_state_next = LOCK_BYPASS;
            rst_hold_next   = 1'b0;
          end
        end
      end
      LOCK_ACQUIRE: begin
        if (fb_change || ref_change_evt) begin
          relock_cnt_next = 32'(RELOCK_CYCLES);
        end else if (relock_cnt_reg <= 32'h1) begin
          lock_state_next = LOCK_LOCKED;
          lock_next       = 1'b1;
          rst_hold_next   = 1'b0;
          irq_set[`IRQ_LOCK_GAIN_POS] = 1'b1;
        end else begin
          relock_cnt_next = relock_cnt_reg - 32'h1;
        end
      end
      LOCK_LOCKED: begin
        if (fb_change || ref_change_evt) begin
          lock_state_next = LOCK_ACQUIRE;
          lock_next       = 1'b0;
          relock_cnt_next = 32'(RELOCK_CYCLES);
          irq_set[`IRQ_LOCK_LOSS_POS] = 1'b1;
        end
      end
      LOCK_BYPASS: begin
        lock_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_state_reg <= LOCK_STRAP;
      relock_cnt_reg <= 32'h0;
      lock_reg       <= 1'b0;
      rst_hold_reg   <= 1'b1;
    end else begin
      lock_state_reg <= lock_state_next;
      relock_cnt_reg <= relock_cnt_next;
      lock_reg       <= lock_next;
      rst_hold_reg   <= rst_hold_next;
    end
  end

  // Outputs toward the analog loop and the system
  assign synth_lock_flag_o = lock_reg;
  assign sys_rst_n_o       = ~rst_hold_reg;
  assign pll_enable_o      = (lock_state_reg == LOCK_ACQUIRE) ||
                             (lock_state_reg == LOCK_LOCKED);
  assign vco_div2_o        = cfg_reg.div_sel;
  assign relock_o          = (lock_state_reg == LOCK_ACQUIRE);
  assign feedback_cfg_o    = {1'b0, cfg_reg.prescale, cfg_reg.modulus};

endmodule // clk_synth_ctrl

// File: ref_source.sv
// External reference source: clock mode strap and comparator input steps
module ref_source (
  input  wire logic clock_i,
  output logic      clock_mode_strap_o,
  output logic      ref_change_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle levels from time zero
  initial begin
    clock_mode_strap_o = 1'b1;
    ref_change_o = 1'b0;
  end
  // Strap level presented while reset is held
  task automatic set_strap(input logic pll_on);
    @(posedge clock_i);
    clock_mode_strap_o <= pll_on;
  endtask
  // Reference step, held long enough for the input synchroniser
  task automatic bump();
    @(posedge clock_i);
    ref_change_o <= 1'b1;
    repeat (4) @(posedge clock_i);
    ref_change_o <= 1'b0;
  endtask
endmodule // ref_source

// File: clk_synth_ctrl_assertions.sv
// Concurrent checks on the clock control block ports
module clk_synth_ctrl_assertions #(
  parameter int RELOCK_CYCLES = 2000
) (
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        ref_clk_change_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        synth_lock_flag_o,
  input wire logic        sys_rst_n_o,
  input wire logic        pll_enable_o,
  input wire logic        vco_div2_o,
  input wire logic        relock_o,
  input wire logic [7:0]  feedback_cfg_o
);
  logic       wr_ctrl;
  logic [6:0] fb_wr;
  logic [6:0] fb_cap;
  logic       div_cap;
  int         relock_cnt;
  // Control word write at its access edge
  assign wr_ctrl = psel_i && penable_i && pwrite_i && (paddr_i == 12'h000);
  assign fb_wr = {pwdata_i[15], pwdata_i[13:8]};
  // Last written settings and length of the current relock
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fb_cap <= 7'h3F;
      div_cap <= 1'b0;
      relock_cnt <= 0;
    end else begin
      fb_cap <= wr_ctrl ? fb_wr : fb_cap;
      div_cap <= wr_ctrl ? pwdata_i[14] : div_cap;
      relock_cnt <= relock_o ? relock_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_fb_change;
    wr_ctrl && pll_enable_o && (fb_wr != feedback_cfg_o[6:0]);
  endsequence
  sequence s_cmp_step;
    $rose(ref_clk_change_i) && synth_lock_flag_o;
  endsequence
  property p_lock_pll; synth_lock_flag_o |-> pll_enable_o && !relock_o; endproperty
  a_lock_pll: assert property (p_lock_pll) else $error("lock without PLL");
  property p_rst_hold; $rose(sys_rst_n_o) |-> synth_lock_flag_o || !pll_enable_o; endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset left early");
  property p_fb_relock; s_fb_change |-> ##[1:3] relock_o; endproperty
  a_fb_relock: assert property (p_fb_relock) else $error("no relock");
  property p_wr_load;
    wr_ctrl ##1 !wr_ctrl |=> vco_div2_o == div_cap && feedback_cfg_o[6:0] == fb_cap;
  endproperty
  a_wr_load: assert property (p_wr_load) else $error("settings not applied");
  property p_div_free;
    wr_ctrl && synth_lock_flag_o && fb_wr == feedback_cfg_o[6:0] && !ref_clk_change_i
      |=> synth_lock_flag_o [*3];
  endproperty
  a_div_free: assert property (p_div_free) else $error("divide caused relock");
  property p_cmp_loss; s_cmp_step |-> ##[1:8] !synth_lock_flag_o; endproperty
  a_cmp_loss: assert property (p_cmp_loss) else $error("lock kept");
  property p_relock_len; relock_cnt <= RELOCK_CYCLES + 8; endproperty
  a_relock_len: assert property (p_relock_len) else $error("relock too long");
  property p_reset_val; $rose(rst_n_i) |-> feedback_cfg_o == 8'h3F && !vco_div2_o; endproperty
  a_reset_val: assert property (p_reset_val) else $error("bad reset value");
endmodule // clk_synth_ctrl_assertions

bind clk_synth_ctrl clk_synth_ctrl_assertions #(.RELOCK_CYCLES(RELOCK_CYCLES)) i_chk (
  .clock_i, .rst_n_i, .ref_clk_change_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .synth_lock_flag_o, .sys_rst_n_o, .pll_enable_o, .vco_div2_o, .relock_o,
  .feedback_cfg_o
);

// File: testbench.sv
// Self-checking bench for the clock control block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock_i = 1'b0, rst_n_i = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, lock, srst_n, pll_en, div2, relock, irq, strap, chg, err;
  logic [7:0]  fb;
  int          num_errors = 0, samples_checked = 0, cycles = 0, w, x, y = 63;
  // 20 MHz clock
  always #25 clock_i = ~clock_i;
  ref_source i_ref (.clock_i(clock_i), .clock_mode_strap_o(strap), .ref_change_o(chg));
  clk_synth_ctrl #(.RELOCK_CYCLES(10)) i_dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .clock_mode_strap_i(strap),
    .ref_clk_change_i(chg), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .synth_lock_flag_o(lock), .sys_rst_n_o(srst_n),
    .pll_enable_o(pll_en), .vco_div2_o(div2), .relock_o(relock), .feedback_cfg_o(fb),
    .irq_o(irq));
  // Verdict and end of run
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Comparison of one result
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One APB transfer; response and read data taken at the access edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    pen <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clock_i);
  endtask
  // Bounded wait for the lock flag to reach a level
  task automatic wait_lock(input logic v);
    int n;
    n = 0;
    while (lock !== v && n < 200) begin
      @(posedge clock_i);
      n++;
    end
    chk("lock flag", v, lock);
  endtask
  // Reset held eleven cycles with the chosen strap
  task automatic do_reset(input logic pll_on);
    rst_n_i <= 1'b0;
    i_ref.set_strap(pll_on);
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
  endtask
  // Cycle ceiling against a hung wait
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  // Main sequence
  initial begin
    void'($urandom(32'h106E));
    do_reset(1'b1);
    wait_lock(1'b1);
    chk("reset out", 1, srst_n);
    apb(0, 12'h000, 0);
    chk("ctrl", 32'h3F08, rd);
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 0 : $urandom_range(1);
      x = (w == 1) ? 1 : ((i == 0) ? 0 : $urandom_range(1));
      y = (i == 0) ? 0 : (y + 1 + $urandom_range(30)) % 32;
      apb(1, 12'h000, (w << 15) | (x << 14) | (y << 8) | 8);
      wait_lock(1'b0);
      wait_lock(1'b1);
      chk("vco div", x, div2);
      apb(0, 12'h000, 0);
      chk("ctrl", (w << 15) | (x << 14) | (y << 8) | 8, rd);
      apb(0, 12'h00C, 0);
      chk("mult", (((y + 1) << (2 * w + x)) << 16) | ((4 * (y + 1)) << (2 * w + x)), rd);
    end
    apb(1, 12'h000, (w << 15) | ((1 - x) << 14) | (y << 8));
    chk("lock kept", 1, lock);
    chk("vco div", 1 - x, div2);
    apb(1, 12'h004, 32'h3);
    apb(1, 12'h008, 32'h2);
    chk("irq idle", 0, irq);
    i_ref.bump();
    wait_lock(1'b0);
    wait_lock(1'b1);
    chk("irq", 1, irq);
    apb(0, 12'h004, 0);
    chk("status", 32'h3, rd);
    apb(1, 12'h004, 32'h3);
    chk("irq clear", 0, irq);
    apb(0, 12'h0FC, 0);
    chk("unmapped", 1, err);
    do_reset(1'b0);
    repeat (20) @(posedge clock_i);
    chk("bypass", 32'h2, {pll_en, srst_n, lock});
    apb(0, 12'h010, 0);
    chk("mode", 32'h2, rd);
    wrap_up();
  end
endmodule // testbench
